// ==== break_comparator.sv ====
// Two-channel user break comparator with an AXI4-Lite register slave.
`timescale 1ns/100ps
module break_comparator
   import break_comparator_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Observed bus cycles
   input wire bus_cycle_t logic_bus,
   input wire bus_cycle_t internal_bus,
   input wire bus_cycle_t xmem_bus,
   input wire bus_cycle_t ymem_bus,
   // Executed branches
   input wire branch_t branch,
   // Break request to the CPU
   output logic break_req,
   output logic break_after,
   output logic [1:0] break_chan,
   input wire logic break_ack,
   // Interrupt
   output logic irq
);

   state_t s_q;
   state_t s_d;

   // Address, mask and all enabled qualifiers are judged on one and the same cycle.
   function automatic logic cycle_match(bus_cycle_t c, logic [31:0] ref_addr, logic [31:0] mask,
                                        logic [15:0] qual);
      logic [1:0] id;
      logic [1:0] rw;
      logic [1:0] sz;
      logic type_ok;
      logic dir_ok;
      logic size_ok;
      logic addr_ok;
      id = qual[QUAL_ID_LSB +: 2];
      rw = qual[QUAL_RW_LSB +: 2];
      sz = qual[QUAL_SZ_LSB +: 2];
      type_ok = (id[0] & c.fetch) | (id[1] & ~c.fetch);
      dir_ok = (rw[0] & ~c.write) | (rw[1] & c.write);
      size_ok = (sz == SIZE_ANY) | (sz == c.size);
      addr_ok = ((c.addr ^ ref_addr) & ~mask) == 32'h0000_0000;
      return c.valid & type_ok & dir_ok & size_ok & addr_ok;
   endfunction

   function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] val, logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Returns the error flag above the read data.
   function automatic logic [32:0] read_word(state_t s, logic [11:0] a);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      if ((a & ~12'h01C) == OFS_TRACE_SRC) begin
         r[31:0] = s.tr_src[a[4:2]];
      end else if ((a & ~12'h01C) == OFS_TRACE_DST) begin
         r[31:0] = s.tr_dst[a[4:2]];
      end else begin
         unique case (a)
            OFS_A_ADDR: r[31:0] = s.a_addr;
            OFS_A_MASK: r[31:0] = s.a_mask;
            OFS_A_QUAL: r[31:0] = {16'h0000, s.a_qual & QUAL_WMASK};
            OFS_B_ADDR: r[31:0] = s.b_addr;
            OFS_B_MASK: r[31:0] = s.b_mask;
            OFS_B_QUAL: r[31:0] = {16'h0000, s.b_qual & QUAL_WMASK};
            OFS_B_DATA: r[31:0] = s.b_data;
            OFS_B_DMASK: r[31:0] = s.b_dmask;
            OFS_CTRL: r[31:0] = {{(32-CTRL_W){1'b0}}, s.ctrl};
            OFS_REP_TARGET: r[31:0] = {{(32-REP_W){1'b0}}, s.rep_target};
            OFS_REP_COUNT: r[31:0] = {{(32-REP_W){1'b0}}, s.rep_count};
            OFS_STATUS: r[31:0] = {{(32-ST_W){1'b0}}, s.status};
            OFS_IMASK: r[31:0] = {{(32-ST_W){1'b0}}, s.imask};
            OFS_TRACE_INFO: r[31:0] = {{(28-TRACE_PTR_W){1'b0}}, s.tr_ptr, s.tr_fill};
            default: r[32] = 1'b1;
         endcase
      end
      return r;
   endfunction

   bus_cycle_t a_cyc;
   bus_cycle_t b_cyc;
   logic [31:0] b_addr_dc;
   logic [31:0] b_data_dc;
   logic a_hit;
   logic b_hit;
   logic b_event;
   logic b_fire;
   logic a_fire;
   logic seq;
   logic do_write;
   logic [ST_W-1:0] st_clr;
   logic [ST_W-1:0] st_set;
   logic [31:0] wval;
   logic [32:0] rd;
   logic [REP_W-1:0] rep_next;

   always_comb begin
      s_d = s_q;
      st_clr = '0;
      st_set = '0;
      wval = apply_strb(32'h0000_0000, s_q.w_data, s_q.w_strb);
      rd = read_word(s_q, araddr);
      seq = s_q.ctrl[CTRL_SEQ];

      // Channel A watches the logic or internal bus only.
      a_cyc = (s_q.a_qual[QUAL_BUS_LSB +: 2] == ASEL_INTERNAL) ? internal_bus : logic_bus;
      a_hit = (s_q.a_qual[QUAL_BUS_LSB +: 2] != 2'h0) & cycle_match(a_cyc, s_q.a_addr, s_q.a_mask, s_q.a_qual);

      // Memory buses are 16 bits wide; the unused register bits become don't care.
      b_cyc = logic_bus;
      b_addr_dc = 32'h0000_0000;
      b_data_dc = 32'h0000_0000;
      unique case (s_q.b_qual[QUAL_BUS_LSB +: 2])
         BSEL_LOGIC: b_cyc = logic_bus;
         BSEL_INTERNAL: b_cyc = internal_bus;
         BSEL_XMEM: begin
            b_cyc = xmem_bus;
            b_cyc.addr = {xmem_bus.addr[15:1], 17'h00000};
            b_cyc.data = {xmem_bus.data[15:0], 16'h0000};
            b_addr_dc = 32'h0001_FFFF;
            b_data_dc = 32'h0000_FFFF;
         end
         BSEL_YMEM: begin
            b_cyc = ymem_bus;
            b_cyc.addr = {16'h0000, ymem_bus.addr[15:1], 1'b0};
            b_cyc.data = {16'h0000, ymem_bus.data[15:0]};
            b_addr_dc = 32'hFFFF_0001;
            b_data_dc = 32'hFFFF_0000;
         end
      endcase
      b_hit = cycle_match(b_cyc, s_q.b_addr, s_q.b_mask | b_addr_dc, s_q.b_qual)
              & (~s_q.ctrl[CTRL_B_DATA_EN]
                 | (((b_cyc.data ^ s_q.b_data) & ~(s_q.b_dmask | b_data_dc)) == 32'h0000_0000));

      // In sequential mode B only counts once A was seen in an earlier cycle; s_q.armed is not yet set on A's own cycle.
      b_event = b_hit & (~seq | s_q.armed);
      rep_next = REP_W'(s_q.rep_count + 12'h001);
      b_fire = b_event & (rep_next >= s_q.rep_target);
      if (b_event) begin
         s_d.rep_count = b_fire ? 12'h000 : rep_next;
      end
      a_fire = a_hit & ~seq;
      s_d.armed = seq & ((s_q.armed & ~b_fire) | a_hit);

      // Break request to the CPU; a new break wins over the acknowledge.
      if (a_fire | b_fire) begin
         s_d.break_req = 1'b1;
         s_d.break_chan = {b_fire, a_fire};
         s_d.break_after = (a_fire & a_cyc.fetch & s_q.ctrl[CTRL_A_AFTER])
                           | (b_fire & b_cyc.fetch & s_q.ctrl[CTRL_B_AFTER]);
      end else if (break_ack) begin
         s_d.break_req = 1'b0;
         s_d.break_chan = 2'h0;
         s_d.break_after = 1'b0;
      end
      st_set[ST_A_MATCH] = a_hit;
      st_set[ST_B_MATCH] = b_hit;
      st_set[ST_BREAK] = a_fire | b_fire;

      // Branch trace ring; the oldest pair is overwritten once all eight are used.
      if (branch.valid) begin
         s_d.tr_src[s_q.tr_ptr] = branch.src;
         s_d.tr_dst[s_q.tr_ptr] = branch.dst;
         s_d.tr_ptr = TRACE_PTR_W'(s_q.tr_ptr + 3'h1);
         if (s_q.tr_fill != 4'h8) begin
            s_d.tr_fill = 4'(s_q.tr_fill + 4'h1);
         end
      end

      // Write address and data are taken in either order.
      if (awvalid & s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid & s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid & bready) begin
         s_d.bvalid = 1'b0;
      end
      do_write = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
      if (do_write) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         unique case (s_q.aw_addr)
            OFS_A_ADDR: s_d.a_addr = apply_strb(s_q.a_addr, s_q.w_data, s_q.w_strb);
            OFS_A_MASK: s_d.a_mask = apply_strb(s_q.a_mask, s_q.w_data, s_q.w_strb);
            OFS_A_QUAL: s_d.a_qual = 16'(apply_strb({16'h0000, s_q.a_qual}, s_q.w_data, s_q.w_strb)) & QUAL_WMASK;
            OFS_B_ADDR: s_d.b_addr = apply_strb(s_q.b_addr, s_q.w_data, s_q.w_strb);
            OFS_B_MASK: s_d.b_mask = apply_strb(s_q.b_mask, s_q.w_data, s_q.w_strb);
            OFS_B_QUAL: s_d.b_qual = 16'(apply_strb({16'h0000, s_q.b_qual}, s_q.w_data, s_q.w_strb)) & QUAL_WMASK;
            OFS_B_DATA: s_d.b_data = apply_strb(s_q.b_data, s_q.w_data, s_q.w_strb);
            OFS_B_DMASK: s_d.b_dmask = apply_strb(s_q.b_dmask, s_q.w_data, s_q.w_strb);
            OFS_CTRL: begin
               s_d.ctrl = CTRL_W'(apply_strb({{(32-CTRL_W){1'b0}}, s_q.ctrl}, s_q.w_data, s_q.w_strb));
               s_d.armed = 1'b0;
            end
            OFS_REP_TARGET: begin
               // Changing the target restarts the count so a stale tally cannot fire early.
               s_d.rep_target = REP_W'(apply_strb({{(32-REP_W){1'b0}}, s_q.rep_target}, s_q.w_data, s_q.w_strb));
               s_d.rep_count = 12'h000;
            end
            OFS_STATUS: st_clr = wval[ST_W-1:0];
            OFS_IMASK: s_d.imask = ST_W'(apply_strb({{(32-ST_W){1'b0}}, s_q.imask}, s_q.w_data, s_q.w_strb));
            OFS_REP_COUNT, OFS_TRACE_INFO: s_d.bresp = RESP_OKAY;
            default: begin
               if (((s_q.aw_addr & ~12'h01C) != OFS_TRACE_SRC) && ((s_q.aw_addr & ~12'h01C) != OFS_TRACE_DST)) begin
                  s_d.bresp = RESP_SLVERR;
               end
            end
         endcase
      end
      s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
      s_d.wready = ~s_d.w_have & ~s_d.bvalid;

      // Read channel: one read at a time, answered one cycle after it is taken.
      if (arvalid & s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rdata = rd[31:0];
         s_d.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
      end else if (s_q.rvalid & rready) begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b1;
      end

      // A hardware event in the clearing cycle survives the clear.
      s_d.status = (s_q.status & ~st_clr) | st_set;
      s_d.irq = |(s_d.status & s_d.imask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign break_req = s_q.break_req;
   assign break_after = s_q.break_after;
   assign break_chan = s_q.break_chan;
   assign irq = s_q.irq;

endmodule // break_comparator

// ==== break_comparator_asserts.sv ====
// Concurrent checks on the break comparator ports.
`timescale 1ns/100ps
module break_comparator_asserts
   import break_comparator_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // Observed buses and break handshake
   input wire bus_cycle_t logic_bus,
   input wire bus_cycle_t internal_bus,
   input wire bus_cycle_t xmem_bus,
   input wire bus_cycle_t ymem_bus,
   input wire logic break_req,
   input wire logic break_after,
   input wire logic [1:0] break_chan,
   input wire logic break_ack
);
   default clocking dcb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire any_valid = logic_bus.valid | internal_bus.valid | xmem_bus.valid | ymem_bus.valid;
   wire any_fetch = logic_bus.valid & logic_bus.fetch | internal_bus.valid & internal_bus.fetch
      | xmem_bus.valid & xmem_bus.fetch | ymem_bus.valid & ymem_bus.fetch;

   AST_BREAK_HOLD: assert property (break_req && !break_ack |=> break_req)
      else $error("break request dropped before acknowledge");
   AST_ACK_CLEAR: assert property (break_req && break_ack && !any_valid |=> !break_req)
      else $error("break request kept after acknowledge");
   AST_CHAN_FLAG: assert property (break_req == (break_chan != 2'h0))
      else $error("channel flags disagree with break request");
   AST_RISE_CAUSE: assert property ($rose(break_req) |-> $past(any_valid))
      else $error("break without an observed bus cycle");
   AST_CHAN_A_BUS: assert property ($rose(break_chan[0]) |-> $past(logic_bus.valid || internal_bus.valid))
      else $error("channel A fired without a logic or internal cycle");
   AST_AFTER_FETCH: assert property ($rose(break_after) |-> $past(any_fetch))
      else $error("after-execution break without a fetch");
   AST_READ_LAT: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   AST_READ_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer not held");
   AST_WRITE_LAT: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   AST_WRITE_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response not held");
endmodule // break_comparator_asserts

bind break_comparator break_comparator_asserts chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .logic_bus,
   .internal_bus, .xmem_bus, .ymem_bus, .break_req, .break_after, .break_chan, .break_ack);

// ==== break_comparator_cpu.sv ====
// Behavioural CPU that enters the break exception after a set delay.
`timescale 1ns/100ps
module break_comparator_cpu (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Break handshake
   input wire logic break_req,
   input wire logic [2:0] delay,
   output logic break_ack
);
   logic [2:0] wait_q;
   // A slow delay lets the request stand for several cycles, as a busy core would.
   always_ff @(posedge aclk) begin
      if (!aresetn || !break_req || break_ack) begin
         wait_q <= 3'h0;
         break_ack <= 1'b0;
      end else begin
         wait_q <= wait_q + 3'h1;
         break_ack <= (wait_q == delay);
      end
   end
endmodule // break_comparator_cpu

// ==== break_comparator_pkg.sv ====
// Constants, register map and types shared by the break comparator design.
package break_comparator_pkg;

   // Register byte offsets.
   localparam logic [11:0] OFS_A_ADDR = 12'h000;
   localparam logic [11:0] OFS_A_MASK = 12'h004;
   localparam logic [11:0] OFS_A_QUAL = 12'h008;
   localparam logic [11:0] OFS_B_ADDR = 12'h00C;
   localparam logic [11:0] OFS_B_MASK = 12'h010;
   localparam logic [11:0] OFS_B_QUAL = 12'h014;
   localparam logic [11:0] OFS_B_DATA = 12'h018;
   localparam logic [11:0] OFS_B_DMASK = 12'h01C;
   localparam logic [11:0] OFS_CTRL = 12'h020;
   localparam logic [11:0] OFS_REP_TARGET = 12'h024;
   localparam logic [11:0] OFS_REP_COUNT = 12'h028;
   localparam logic [11:0] OFS_STATUS = 12'h02C;
   localparam logic [11:0] OFS_IMASK = 12'h030;
   localparam logic [11:0] OFS_TRACE_INFO = 12'h034;
   localparam logic [11:0] OFS_TRACE_SRC = 12'h040;
   localparam logic [11:0] OFS_TRACE_DST = 12'h060;
   localparam logic [11:0] OFS_TRACE_SEL = 12'hFE3;

   // Qualifier field positions; only the low byte is implemented.
   localparam int QUAL_SZ_LSB = 0;
   localparam int QUAL_RW_LSB = 2;
   localparam int QUAL_ID_LSB = 4;
   localparam int QUAL_BUS_LSB = 6;
   localparam logic [15:0] QUAL_WMASK = 16'h00FF;

   // Bus select codes of channel B.
   localparam logic [1:0] BSEL_LOGIC = 2'h0;
   localparam logic [1:0] BSEL_INTERNAL = 2'h1;
   localparam logic [1:0] BSEL_XMEM = 2'h2;
   localparam logic [1:0] BSEL_YMEM = 2'h3;
   // Channel A bus select code that picks the internal bus.
   localparam logic [1:0] ASEL_INTERNAL = 2'h2;
   localparam logic [1:0] SIZE_ANY = 2'h0;

   // Control register bits.
   localparam int CTRL_SEQ = 0;
   localparam int CTRL_A_AFTER = 1;
   localparam int CTRL_B_AFTER = 2;
   localparam int CTRL_B_DATA_EN = 3;
   localparam int CTRL_W = 4;

   // Status and mask bits.
   localparam int ST_A_MATCH = 0;
   localparam int ST_B_MATCH = 1;
   localparam int ST_BREAK = 2;
   localparam int ST_W = 3;

   localparam int REP_W = 12;
   localparam int TRACE_DEPTH = 8;
   localparam int TRACE_PTR_W = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One observed bus cycle; size uses the qualifier size codes.
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] data;
   } bus_cycle_t;

   // One executed branch.
   typedef struct packed {
      logic valid;
      logic [31:0] src;
      logic [31:0] dst;
   } branch_t;

   typedef struct packed {
      logic [31:0] a_addr;
      logic [31:0] a_mask;
      logic [15:0] a_qual;
      logic [31:0] b_addr;
      logic [31:0] b_mask;
      logic [15:0] b_qual;
      logic [31:0] b_data;
      logic [31:0] b_dmask;
      logic [CTRL_W-1:0] ctrl;
      logic [REP_W-1:0] rep_target;
      logic [REP_W-1:0] rep_count;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] imask;
      logic armed;
      logic [TRACE_DEPTH-1:0][31:0] tr_src;
      logic [TRACE_DEPTH-1:0][31:0] tr_dst;
      logic [TRACE_PTR_W-1:0] tr_ptr;
      logic [TRACE_PTR_W:0] tr_fill;
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic break_req;
      logic break_after;
      logic [1:0] break_chan;
      logic irq;
   } state_t;

   localparam state_t STATE_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// ==== break_comparator_test.sv ====
// Self-checking bench for the break comparator.
`timescale 1ns/100ps
module break_comparator_test;
   import break_comparator_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, break_req, break_after, break_ack, irq;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, break_chan;
   bus_cycle_t logic_bus = '0, internal_bus = '0, xmem_bus = '0, ymem_bus = '0;
   branch_t branch = '0;
   logic [2:0] delay = 3'h0;
   integer seed = 99030;
   int miscompares = 0, n_tests = 0, cycles = 0;
   logic [1:0] wr_resp = 2'h0;

   always #12.5 aclk = ~aclk;

   break_comparator dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .logic_bus, .internal_bus, .xmem_bus, .ymem_bus, .branch, .break_req,
      .break_after, .break_chan, .break_ack, .irq);
   break_comparator_cpu cpu_u (.aclk, .aresetn, .break_req, .delay, .break_ack);

   task complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         complete_run();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // The response ready is raised late on purpose so the slave must hold its answer.
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      repeat (2) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   function automatic bus_cycle_t rc(input logic v);
      logic [95:0] r;
      r = {$random(seed), $random(seed), $random(seed)};
      rc = r[68:0];
      rc.valid = v;
   endfunction

   function automatic logic exp_a(input logic [15:0] q, input logic [31:0] ra, input logic [31:0] rm,
      input bus_cycle_t c, input logic on_int);
      logic bus_ok;
      bus_ok = (q[7:6] == ASEL_INTERNAL) ? on_int : (q[7:6] != 2'h0 && !on_int);
      return c.valid && bus_ok && (q[4] && c.fetch || q[5] && !c.fetch)
         && (q[2] && !c.write || q[3] && c.write)
         && (q[1:0] == 2'h0 || q[1:0] == c.size)
         && ((c.addr ^ ra) & ~rm) == 32'h0;
   endfunction

   // Idle buses carry fresh noise so a stale value can never pass for a cycle.
   task pulse(input bus_cycle_t l, input bus_cycle_t i, input bus_cycle_t x, input bus_cycle_t y);
      logic_bus <= l;
      internal_bus <= i;
      xmem_bus <= x;
      ymem_bus <= y;
      @(posedge aclk);
      logic_bus <= rc(1'b0);
      internal_bus <= rc(1'b0);
      xmem_bus <= rc(1'b0);
      ymem_bus <= rc(1'b0);
      @(posedge aclk);
   endtask

   task wait_free;
      while (break_req) @(posedge aclk);
   endtask

   initial begin
      logic [31:0] d, ra, rm, ctl, im;
      logic [15:0] q;
      logic [1:0] r;
      logic on_int, e;
      bus_cycle_t c;
      bus_cycle_t bs [4];
      logic [31:0] ts [8];
      logic [31:0] td [8];
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 3; i++) begin
         rd(OFS_A_ADDR + 12'(4 * i), d, r);
         chk(d, 32'h0);
      end
      wr(OFS_A_QUAL, 32'h00FF);
      chk(wr_resp, RESP_OKAY);
      rd(OFS_A_QUAL, d, r);
      chk(d, 32'h00FF);
      wr(12'h0F0, 32'h1);
      chk(wr_resp, RESP_SLVERR);
      rd(12'h0F0, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      // Only the two low byte lanes may change.
      wstrb <= 4'h3;
      wr(OFS_B_DATA, 32'hFFFF_FFFF);
      wstrb <= 4'hF;
      rd(OFS_B_DATA, d, r);
      chk(d, 32'h0000_FFFF);
      // Nine branches wrap the eight-slot ring once.
      for (int n = 0; n < 9; n++) begin
         ts[n % 8] = $random(seed);
         td[n % 8] = $random(seed);
         branch <= {1'b1, ts[n % 8], td[n % 8]};
         @(posedge aclk);
      end
      branch <= '0;
      for (int n = 0; n < 8; n++) begin
         rd(OFS_TRACE_SRC + 12'(4 * n), d, r);
         chk(d, ts[n]);
         rd(OFS_TRACE_DST + 12'(4 * n), d, r);
         chk(d, td[n]);
      end
      rd(OFS_TRACE_INFO, d, r);
      chk(d, 32'h0000_0018);
      for (int t = 0; t < 150; t++) begin
         ra = $random(seed);
         rm = $random(seed) & $random(seed);
         q = 16'($random(seed)) & 16'h00FF;
         if (t[1]) q[5:2] = 4'hF;
         ctl = $random(seed) & 32'h2;
         im = $random(seed) & 32'h1;
         delay <= 3'($random(seed));
         wr(OFS_A_ADDR, ra);
         wr(OFS_A_MASK, rm);
         wr(OFS_A_QUAL, {16'h0, q});
         wr(OFS_CTRL, ctl);
         wr(OFS_IMASK, im);
         rd(OFS_A_ADDR, d, r);
         chk(d, ra);
         rd(OFS_A_MASK, d, r);
         chk(d, rm);
         c = rc(1'b1);
         c.addr = ra ^ ($random(seed) & (t[0] ? rm : $random(seed)));
         on_int = 1'($random(seed));
         if (on_int) pulse(rc(1'b0), c, rc(1'b1), rc(1'b1));
         else pulse(c, rc(1'b0), rc(1'b1), rc(1'b1));
         e = exp_a(q, ra, rm, c, on_int);
         chk(break_req, e);
         chk(break_chan, {1'b0, e});
         chk(break_after, e && c.fetch && ctl[CTRL_A_AFTER]);
         chk(irq, e && im[0]);
         wr(OFS_STATUS, 32'h7);
         wait_free();
         @(posedge aclk);
         chk(irq, 1'b0);
      end
      wr(OFS_B_MASK, 32'hFFFFFFFF);
      wr(OFS_B_QUAL, 32'h3C);
      wr(OFS_A_MASK, 32'hFFFFFFFF);
      wr(OFS_A_QUAL, 32'hBC);
      wr(OFS_CTRL, 32'h1);
      for (int k = 0; k < 7; k++) begin
         if (k == 3) wr(OFS_CTRL, 32'h0);
         if (k == 4) wr(OFS_REP_TARGET, 32'h3);
         pulse(rc(1'b1), rc(k == 0), rc(1'b1), rc(1'b1));
         e = (k == 1 || k == 3 || k == 6);
         chk(break_req, e);
         chk(break_chan, {e, 1'b0});
         wait_free();
      end
      wr(OFS_A_QUAL, 32'h0);
      wr(OFS_B_MASK, 32'h0);
      wr(OFS_REP_TARGET, 32'h1);
      wr(OFS_CTRL, 32'hC);
      // Each bus select in turn, once matching and once with one compared data bit flipped.
      for (int j = 0; j < 8; j++) begin
         c = rc(1'b1);
         ra = $random(seed);
         rm = $random(seed);
         ra = j[1] ? (j[0] ? {ra[31:16], c.addr[15:1], ra[0]} : {c.addr[15:1], ra[16:0]}) : c.addr;
         rm = j[1] ? (j[0] ? {rm[31:16], c.data[15:0]} : {c.data[15:0], rm[15:0]}) : c.data;
         wr(OFS_B_ADDR, ra);
         wr(OFS_B_DATA, rm);
         wr(OFS_B_QUAL, {24'h0, j[1:0], 6'h3C});
         for (int n = 0; n < 4; n++) bs[n] = rc(1'b1);
         c.data[0] = c.data[0] ^ j[2];
         bs[j[1:0]] = c;
         pulse(bs[0], bs[1], bs[2], bs[3]);
         e = !j[2];
         chk(break_req, e);
         chk(break_chan, {e, 1'b0});
         chk(break_after, e && c.fetch);
         wait_free();
      end
      complete_run();
   end
endmodule // break_comparator_test
